// [hdl/ptp_port_detect.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ptp_ts_cfg.svh"

module ptp_port_detect (
    // clock and synchronised reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    // configuration
    input  wire ptp_ts_pkg::port_cfg_t  port_cfg_in,
    input  wire logic [47:0]            user_addr_in,
    // frame event from the port
    input  wire logic                   frame_valid_in,
    input  wire logic                   frame_tx_in,
    input  wire logic                   msg_sync_in,
    input  wire logic                   msg_delay_req_in,
    input  wire logic [47:0]            dest_addr_in,
    // results
    output logic                        ptp_frame_out,
    output logic                        capture_out
);
    import ptp_ts_pkg::*;

    detect_state_t s_q;     // registered state
    detect_state_t s_d;     // next state

    // ==========================================
    // address recognition
    // true when the address is one of those enabled for this port
    function automatic logic addr_enabled(
        input port_cfg_t   cfg,
        input logic [47:0] user,
        input logic [47:0] da
    );
        logic hit;
        hit = 1'b0;
        if (cfg.primary_en && da == `PTP_ADDR_PRIMARY) hit = 1'b1;
        if (cfg.alt1_en && da == `PTP_ADDR_ALT1) hit = 1'b1;
        if (cfg.alt2_en && da == `PTP_ADDR_ALT2) hit = 1'b1;
        if (cfg.alt3_en && da == `PTP_ADDR_ALT3) hit = 1'b1;
        if (cfg.user_en && da == user) hit = 1'b1;
        return hit;
    endfunction

    // ==========================================
    // next state
    // capture direction depends on master or slave role
    always_comb begin
        logic is_ptp;
        is_ptp = addr_enabled(port_cfg_in, user_addr_in, dest_addr_in);
        s_d = s_q;
        s_d.capture = 1'b0;
        if (frame_valid_in) begin
            s_d.ptp_frame = is_ptp;
            if (is_ptp && port_cfg_in.master_sel) begin
                // master: sync out, delay request in
                s_d.capture = frame_tx_in ? msg_sync_in : msg_delay_req_in;
            end else if (is_ptp) begin
                // slave: delay request out, sync in
                s_d.capture = frame_tx_in ? msg_delay_req_in : msg_sync_in;
            end
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ptp_frame_out = s_q.ptp_frame;
    assign capture_out   = s_q.capture;

endmodule
`default_nettype wire

// [hdl/ptp_timestamp_config.sv]
// Behaviour
// - on compare event, update compare from reload
// - config bit picks reload or add
// - reload takes effect after both halves written
// - reload lower word, read/write, resets zero
// - add mode accumulates for periodic events
// - user address built from two registers
// - user upper holds 16 bits, rest zero
// - user lower holds 32 bits, resets zero
// - user address used only when enabled
// - one config register, bit group per port
// - master captures sync out, delay request in
// - slave captures delay request out, sync in
// - bit 30 enables primary address, resets one
// - bit 29 enables alternate address one
// - compare target against clock, raise event
// - reload upper word, read/write, resets zero
`timescale 1ns/1ps
`default_nettype none
`include "ptp_ts_cfg.svh"

module ptp_timestamp_config (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    // management register port
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [8:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic [31:0]      reg_rdata_out,
    output logic             reg_rvalid_out,
    // running time clock
    input  wire logic [63:0] time_clock_in,
    // compare results
    output logic             compare_event_out,
    output logic [63:0]      compare_value_out,
    // port 1 frame events
    input  wire logic        port1_frame_valid_in,
    input  wire logic        port1_frame_tx_in,
    input  wire logic        port1_msg_sync_in,
    input  wire logic        port1_msg_delay_req_in,
    input  wire logic [47:0] port1_dest_addr_in,
    // port 2 frame events
    input  wire logic        port2_frame_valid_in,
    input  wire logic        port2_frame_tx_in,
    input  wire logic        port2_msg_sync_in,
    input  wire logic        port2_msg_delay_req_in,
    input  wire logic [47:0] port2_dest_addr_in,
    // port 1 detection results
    output logic             port1_ptp_frame_out,
    output logic             port1_capture_out,
    // port 2 detection results
    output logic             port2_ptp_frame_out,
    output logic             port2_capture_out
);
    import ptp_ts_pkg::*;

    // ==========================================
    // reset release
    logic      rst_meta_q;      // first stage, feeds second only
    logic      rst_n_sync_q;    // released reset for all logic

    // ==========================================
    // block state
    ts_state_t s_q;             // registered state
    ts_state_t s_d;             // next state

    // ==========================================
    // derived configuration
    port_cfg_t   port1_cfg;     // port 1 bit group
    port_cfg_t   port2_cfg;     // port 2 bit group
    logic [47:0] user_addr;     // assembled user address
    logic        add_mode;      // 1: accumulate, 0: reload

    // ==========================================
    // helper functions
    // read answer for an address; unmapped reads give zero
    function automatic logic [31:0] read_word(
        input ts_state_t  st,
        input logic [8:0] addr
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (addr)
            `OFS_TARGET_HIGH: begin
                w = st.target_hi;
            end
            `OFS_TARGET_LOW: begin
                w = st.target_lo;
            end
            `OFS_RELOAD_UPPER: begin
                w = st.reload_hi;
            end
            `OFS_RELOAD_LOWER: begin
                w = st.reload_lo;
            end
            `OFS_USER_ADDR_UPPER: begin
                w = {16'h0000, st.user_upper};
            end
            `OFS_USER_ADDR_LOWER: begin
                w = st.user_lower;
            end
            `OFS_TS_CONFIG: begin
                w = st.ts_config;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // next compare value after an event
    function automatic logic [63:0] next_compare(
        input logic [63:0] cur,
        input logic [63:0] reload,
        input logic        add
    );
        logic [63:0] v;
        // wraps modulo 2^64, like the time clock itself
        v = add ? (cur + reload) : reload;
        return v;
    endfunction

    // ==========================================
    // reset synchroniser
    // async assert, release after two edges
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q   <= 1'b0;
            rst_n_sync_q <= 1'b0;
        end else begin
            rst_meta_q   <= 1'b1;
            rst_n_sync_q <= rst_meta_q;
        end
    end

    // ==========================================
    // configuration decode
    // each port owns one byte of the config word
    assign port2_cfg = port_cfg_t'(s_q.ts_config[`CFG_PORT2_LSB +: 8]);
    assign port1_cfg = port_cfg_t'(s_q.ts_config[`CFG_PORT1_LSB +: 8]);
    assign user_addr = {s_q.user_upper, s_q.user_lower};
    assign add_mode  = s_q.ts_config[`CFG_RELOAD_ADD_BIT];

    // ==========================================
    // next-state logic
    always_comb begin
        logic        match;     // time equals compare target
        logic        tgt_hi_w;  // target upper written now
        logic        tgt_lo_w;  // target lower written now
        logic        rl_hi_w;   // reload upper written now
        logic        rl_lo_w;   // reload lower written now
        match    = 1'b0;
        tgt_hi_w = 1'b0;
        tgt_lo_w = 1'b0;
        rl_hi_w  = 1'b0;
        rl_lo_w  = 1'b0;
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        s_d.evt    = 1'b0;

        // register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                `OFS_TARGET_HIGH: begin
                    s_d.target_hi = reg_wdata_in;
                    tgt_hi_w      = 1'b1;
                end
                `OFS_TARGET_LOW: begin
                    s_d.target_lo = reg_wdata_in;
                    tgt_lo_w      = 1'b1;
                end
                `OFS_RELOAD_UPPER: begin
                    s_d.reload_hi = reg_wdata_in;
                    rl_hi_w       = 1'b1;
                end
                `OFS_RELOAD_LOWER: begin
                    s_d.reload_lo = reg_wdata_in;
                    rl_lo_w       = 1'b1;
                end
                `OFS_USER_ADDR_UPPER: begin
                    // upper half of the word is read-only
                    s_d.user_upper = reg_wdata_in[15:0];
                end
                `OFS_USER_ADDR_LOWER: begin
                    s_d.user_lower = reg_wdata_in;
                end
                `OFS_TS_CONFIG: begin
                    // unassigned bits stay zero
                    s_d.ts_config = reg_wdata_in & `CFG_WRITE_MASK;
                end
                default: begin
                    // unmapped write is dropped
                end
            endcase
        end

        // register reads, answered one cycle later
        if (reg_rd_in) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = read_word(s_q, reg_addr_in);
        end

        // compare event; suppressed right after one so
        // a zero add step cannot fire every cycle
        match = (time_clock_in == s_q.target_cmp) && !s_q.evt;
        if (match) begin
            s_d.evt        = 1'b1;
            // committed reload only, never half-written
            s_d.target_cmp = next_compare(s_q.target_cmp,
                                          s_q.reload_act,
                                          add_mode);
        end

        // written flags: a new write sets, commit clears
        s_d.reload_hi_wr = s_q.reload_hi_wr | rl_hi_w;
        s_d.reload_lo_wr = s_q.reload_lo_wr | rl_lo_w;
        s_d.target_hi_wr = s_q.target_hi_wr | tgt_hi_w;
        s_d.target_lo_wr = s_q.target_lo_wr | tgt_lo_w;

        // reload commit once both halves are in
        if (s_d.reload_hi_wr && s_d.reload_lo_wr) begin
            s_d.reload_act   = {s_d.reload_hi, s_d.reload_lo};
            s_d.reload_hi_wr = 1'b0;
            s_d.reload_lo_wr = 1'b0;
        end

        // target commit; software value wins over an event
        if (s_d.target_hi_wr && s_d.target_lo_wr) begin
            s_d.target_cmp   = {s_d.target_hi, s_d.target_lo};
            s_d.target_hi_wr = 1'b0;
            s_d.target_lo_wr = 1'b0;
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge core_clk_in or negedge rst_n_sync_q) begin
        if (!rst_n_sync_q) begin
            s_q            <= '0;
            s_q.target_cmp <= {`RST_WORD, `RST_WORD};
            s_q.target_hi  <= `RST_WORD;
            s_q.target_lo  <= `RST_WORD;
            s_q.reload_act <= {`RST_WORD, `RST_WORD};
            s_q.reload_hi  <= `RST_WORD;
            s_q.reload_lo  <= `RST_WORD;
            s_q.user_upper <= `RST_USER_UPPER;
            s_q.user_lower <= `RST_WORD;
            s_q.ts_config  <= `RST_TS_CONFIG;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // port detectors
    // port 1 address match and capture
    ptp_port_detect port1_detect (
        .core_clk_in      (core_clk_in),
        .rst_n_in         (rst_n_sync_q),
        .port_cfg_in      (port1_cfg),
        .user_addr_in     (user_addr),
        .frame_valid_in   (port1_frame_valid_in),
        .frame_tx_in      (port1_frame_tx_in),
        .msg_sync_in      (port1_msg_sync_in),
        .msg_delay_req_in (port1_msg_delay_req_in),
        .dest_addr_in     (port1_dest_addr_in),
        .ptp_frame_out    (port1_ptp_frame_out),
        .capture_out      (port1_capture_out)
    );

    // port 2 address match and capture
    ptp_port_detect port2_detect (
        .core_clk_in      (core_clk_in),
        .rst_n_in         (rst_n_sync_q),
        .port_cfg_in      (port2_cfg),
        .user_addr_in     (user_addr),
        .frame_valid_in   (port2_frame_valid_in),
        .frame_tx_in      (port2_frame_tx_in),
        .msg_sync_in      (port2_msg_sync_in),
        .msg_delay_req_in (port2_msg_delay_req_in),
        .dest_addr_in     (port2_dest_addr_in),
        .ptp_frame_out    (port2_ptp_frame_out),
        .capture_out      (port2_capture_out)
    );

    // ==========================================
    // outputs, all from flip-flops
    assign reg_rdata_out     = s_q.rdata;
    assign reg_rvalid_out    = s_q.rvalid;
    assign compare_event_out = s_q.evt;
    assign compare_value_out = s_q.target_cmp;

endmodule
`default_nettype wire

// [hdl/ptp_ts_cfg.svh]
`ifndef PTP_TS_CFG_SVH
`define PTP_TS_CFG_SVH

// ==========================================
// register byte offsets
`define OFS_TARGET_HIGH      9'h17c
`define OFS_TARGET_LOW       9'h180
`define OFS_RELOAD_UPPER     9'h184
`define OFS_RELOAD_LOWER     9'h188
`define OFS_USER_ADDR_UPPER  9'h18c
`define OFS_USER_ADDR_LOWER  9'h190
`define OFS_TS_CONFIG        9'h194

// ==========================================
// reset values
`define RST_WORD             32'h0000_0000
`define RST_USER_UPPER       16'h0000
`define RST_TS_CONFIG        32'h4343_0000

// ==========================================
// configuration register layout
`define CFG_PORT2_LSB        24
`define CFG_PORT1_LSB        16
`define CFG_RELOAD_ADD_BIT   0
`define CFG_WRITE_MASK       32'hffff_0001

// ==========================================
// predefined time-protocol destination addresses
`define PTP_ADDR_PRIMARY     48'h01005e000181
`define PTP_ADDR_ALT1        48'h01005e000182
`define PTP_ADDR_ALT2        48'h01005e000183
`define PTP_ADDR_ALT3        48'h01005e000184

`endif

// [hdl/ptp_ts_pkg.sv]
// ==========================================
// shared types of the timestamp configuration block
package ptp_ts_pkg;

    // one port's group of eight configuration bits, msb first
    typedef struct packed {
        logic master_sel;   // 1: time master, 0: slave
        logic primary_en;   // primary predefined address
        logic alt1_en;      // alternate address 1
        logic alt2_en;      // alternate address 2
        logic alt3_en;      // alternate address 3
        logic user_en;      // user-defined address
        logic lock_rx;      // capture lock, receive side
        logic lock_tx;      // capture lock, transmit side
    } port_cfg_t;

    // state of one port's detector
    typedef struct packed {
        logic ptp_frame;    // last frame was time-protocol
        logic capture;      // timestamp capture pulse
    } detect_state_t;

    // whole state of the configuration block
    typedef struct packed {
        logic [63:0] target_cmp;    // active compare target
        logic [31:0] target_hi;     // written target, upper
        logic [31:0] target_lo;     // written target, lower
        logic        target_hi_wr;  // upper half written
        logic        target_lo_wr;  // lower half written
        logic [63:0] reload_act;    // reload value in use
        logic [31:0] reload_hi;     // written reload, upper
        logic [31:0] reload_lo;     // written reload, lower
        logic        reload_hi_wr;  // upper half written
        logic        reload_lo_wr;  // lower half written
        logic [15:0] user_upper;    // user address 47:32
        logic [31:0] user_lower;    // user address 31:0
        logic [31:0] ts_config;     // configuration word
        logic [31:0] rdata;         // read answer
        logic        rvalid;        // read answer strobe
        logic        evt;           // compare event pulse
    } ts_state_t;

endpackage

// [verif/ptp_timestamp_config_chk.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// port-level checker
module ptp_timestamp_config_chk (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    // register port
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [31:0] reg_rdata_out,
    input  wire logic        reg_rvalid_out,
    // compare side
    input  wire logic [63:0] time_clock_in,
    input  wire logic        compare_event_out,
    input  wire logic [63:0] compare_value_out,
    // frame detection
    input  wire logic        port1_frame_valid_in,
    input  wire logic        port1_capture_out,
    input  wire logic        port2_frame_valid_in,
    input  wire logic        port2_msg_sync_in,
    input  wire logic        port2_msg_delay_req_in,
    input  wire logic        port2_ptp_frame_out,
    input  wire logic        port2_capture_out
);
    logic [1:0] up_q;   // edges since release
    logic       live;   // internal reset surely lifted

    // ==========================================
    // core reset lags nrst_in by two flops; wait it out
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    assign live = (up_q == 2'h3);

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    // ==========================================
    // register port timing
    a_rd_answers: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("read valid without a read");
    a_rdata_holds: assert property (live && !reg_rvalid_out |-> $stable(reg_rdata_out))
        else $error("read data moved without a read");

    // ==========================================
    // compare event
    a_match_fires: assert property (live && time_clock_in == compare_value_out
        && !compare_event_out && !reg_wr_in |=> compare_event_out)
        else $error("match raised no event");
    a_event_cause: assert property (compare_event_out
        |-> $past(time_clock_in) == $past(compare_value_out))
        else $error("event without match");
    a_event_pulse: assert property (compare_event_out |=> !compare_event_out)
        else $error("compare event too long");
    a_cmp_steady: assert property (live && !compare_event_out && !$past(reg_wr_in)
        |-> $stable(compare_value_out))
        else $error("compare value moved");

    // ==========================================
    // frame detection
    a_cap2_cause: assert property (port2_capture_out |-> $past(port2_frame_valid_in)
        && $past(port2_msg_sync_in || port2_msg_delay_req_in))
        else $error("port 2 capture without message");
    a_cap2_ptp: assert property (port2_capture_out |-> port2_ptp_frame_out)
        else $error("port 2 capture on a non time frame");
    a_cap1_cause: assert property (port1_capture_out |-> $past(port1_frame_valid_in))
        else $error("port 1 capture without a frame");
    a_ptp2_holds: assert property (live && !$past(port2_frame_valid_in)
        |-> $stable(port2_ptp_frame_out))
        else $error("port 2 flag moved without frame");
endmodule

bind ptp_timestamp_config ptp_timestamp_config_chk u_chk (
    .core_clk_in            (core_clk_in),
    .nrst_in                (nrst_in),
    .reg_wr_in              (reg_wr_in),
    .reg_rd_in              (reg_rd_in),
    .reg_rdata_out          (reg_rdata_out),
    .reg_rvalid_out         (reg_rvalid_out),
    .time_clock_in          (time_clock_in),
    .compare_event_out      (compare_event_out),
    .compare_value_out      (compare_value_out),
    .port1_frame_valid_in   (port1_frame_valid_in),
    .port1_capture_out      (port1_capture_out),
    .port2_frame_valid_in   (port2_frame_valid_in),
    .port2_msg_sync_in      (port2_msg_sync_in),
    .port2_msg_delay_req_in (port2_msg_delay_req_in),
    .port2_ptp_frame_out    (port2_ptp_frame_out),
    .port2_capture_out      (port2_capture_out)
);

`default_nettype wire

// [verif/ptp_timestamp_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ptp_ts_cfg.svh"

module ptp_timestamp_config_tb;
    import ptp_ts_pkg::*;

    // ==========================================
    // stimulus and observed signals
    logic        core_clk;        // 250 MHz
    logic        nrst;            // active low reset
    logic        reg_wr;          // write strobe
    logic        reg_rd;          // read strobe
    logic [8:0]  reg_addr;        // byte address
    logic [31:0] reg_wdata;       // write data
    logic [31:0] reg_rdata;       // read data
    logic        reg_rvalid;      // read answer strobe
    logic [63:0] tclk;            // running time clock
    logic        evt;             // compare event
    logic [63:0] cmp;             // compare value
    logic [1:0]  f_v;             // frame valid, index 0 is port 1
    logic [1:0]  f_tx;            // transmitted frame
    logic [1:0]  f_sy;            // sync message
    logic [1:0]  f_dq;            // delay request message
    logic [47:0] f_da [0:1];      // destination address
    logic [1:0]  f_ptp;           // time frame flag
    logic [1:0]  f_cap;           // capture pulse
    int          errors;          // mismatches
    int          compares;        // comparisons made

    localparam logic [47:0] USR = 48'h0123_4567_89ab;  // user address

    ptp_timestamp_config DUT (
        .core_clk_in            (core_clk),
        .nrst_in                (nrst),
        .reg_wr_in              (reg_wr),
        .reg_rd_in              (reg_rd),
        .reg_addr_in            (reg_addr),
        .reg_wdata_in           (reg_wdata),
        .reg_rdata_out          (reg_rdata),
        .reg_rvalid_out         (reg_rvalid),
        .time_clock_in          (tclk),
        .compare_event_out      (evt),
        .compare_value_out      (cmp),
        .port1_frame_valid_in   (f_v[0]),
        .port1_frame_tx_in      (f_tx[0]),
        .port1_msg_sync_in      (f_sy[0]),
        .port1_msg_delay_req_in (f_dq[0]),
        .port1_dest_addr_in     (f_da[0]),
        .port2_frame_valid_in   (f_v[1]),
        .port2_frame_tx_in      (f_tx[1]),
        .port2_msg_sync_in      (f_sy[1]),
        .port2_msg_delay_req_in (f_dq[1]),
        .port2_dest_addr_in     (f_da[1]),
        .port1_ptp_frame_out    (f_ptp[0]),
        .port1_capture_out      (f_cap[0]),
        .port2_ptp_frame_out    (f_ptp[1]),
        .port2_capture_out      (f_cap[1])
    );

    // ==========================================
    // clock
    always #2 core_clk = ~core_clk;

    // ==========================================
    // checks and tasks
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write; strobe drops on the taking edge
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // one read; answer checked just after the taking edge
    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 64'h1, {63'h0, reg_rvalid});
        chk("rdata", {32'h0, exp}, {32'h0, reg_rdata});
    endtask

    // time meets compare for one cycle
    task automatic hit(input logic [63:0] t, input logic [63:0] exp_cmp);
        @(posedge core_clk);
        tclk <= t;
        @(posedge core_clk);
        tclk <= '1;
        #1;
        chk("event", 64'h1, {63'h0, evt});
        chk("compare", exp_cmp, cmp);
    endtask

    // one frame event on port p (0 = port 1)
    task automatic frm(input logic p, input logic tx, input logic sy, input logic dq,
                       input logic [47:0] da, input logic ep, input logic ec);
        @(posedge core_clk);
        f_v[p] <= 1'b1;
        f_tx[p] <= tx;
        f_sy[p] <= sy;
        f_dq[p] <= dq;
        f_da[p] <= da;
        @(posedge core_clk);
        f_v[p] <= 1'b0;
        #1;
        chk("ptp_frame", {63'h0, ep}, {63'h0, f_ptp[p]});
        chk("capture", {63'h0, ec}, {63'h0, f_cap[p]});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog, far past the tests
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end

    // ==========================================
    // main sequence
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 32'h0;
        tclk = '1;  // all ones, clear of compare
        f_v = 2'h0;
        f_tx = 2'h0;
        f_sy = 2'h0;
        f_dq = 2'h0;
        f_da = '{48'h0, 48'h0};
        errors = 0;
        compares = 0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        // reset values and access kinds
        rd(`OFS_RELOAD_LOWER, 32'h0);
        rd(`OFS_RELOAD_UPPER, 32'h0);
        rd(`OFS_USER_ADDR_UPPER, 32'h0);
        rd(`OFS_USER_ADDR_LOWER, 32'h0);
        rd(`OFS_TS_CONFIG, 32'h4343_0000);
        rd(9'h1fc, 32'h0);
        wr(`OFS_USER_ADDR_UPPER, 32'hffff_ffff);
        rd(`OFS_USER_ADDR_UPPER, 32'h0000_ffff);
        wr(`OFS_USER_ADDR_LOWER, 32'ha5a5_a5a5);
        rd(`OFS_USER_ADDR_LOWER, 32'ha5a5_a5a5);
        wr(`OFS_TS_CONFIG, 32'hffff_ffff);
        rd(`OFS_TS_CONFIG, 32'hffff_0001);
        wr(`OFS_TS_CONFIG, 32'h4343_0000);
        $display("test registers done");
        // compare target, reload and add
        wr(`OFS_TARGET_HIGH, 32'h0);
        wr(`OFS_TARGET_LOW, 32'h100);
        #1;
        chk("target", 64'h100, cmp);
        wr(`OFS_RELOAD_LOWER, 32'h40);
        hit(64'h100, 64'h0);
        wr(`OFS_RELOAD_UPPER, 32'h0);
        hit(64'h0, 64'h40);
        rd(`OFS_RELOAD_LOWER, 32'h40);
        wr(`OFS_TS_CONFIG, 32'h4343_0001);
        hit(64'h40, 64'h80);
        hit(64'h80, 64'hc0);
        wr(`OFS_RELOAD_UPPER, 32'h1);
        hit(64'hc0, 64'h100);
        rd(`OFS_RELOAD_UPPER, 32'h1);
        wr(`OFS_RELOAD_LOWER, 32'h0);
        hit(64'h100, 64'h1_0000_0100);
        $display("test compare done");
        // port 2 slave detection
        wr(`OFS_USER_ADDR_UPPER, 32'h0123);
        wr(`OFS_USER_ADDR_LOWER, 32'h4567_89ab);
        frm(1'b1, 1'b0, 1'b1, 1'b0, `PTP_ADDR_PRIMARY, 1'b1, 1'b1);
        frm(1'b1, 1'b1, 1'b1, 1'b0, `PTP_ADDR_PRIMARY, 1'b1, 1'b0);
        frm(1'b1, 1'b1, 1'b0, 1'b1, `PTP_ADDR_PRIMARY, 1'b1, 1'b1);
        frm(1'b1, 1'b0, 1'b1, 1'b0, `PTP_ADDR_ALT1, 1'b0, 1'b0);
        frm(1'b1, 1'b0, 1'b1, 1'b0, USR, 1'b0, 1'b0);
        // port 2 master, alt1 and user on
        wr(`OFS_TS_CONFIG, 32'ha443_0001);
        frm(1'b1, 1'b1, 1'b1, 1'b0, `PTP_ADDR_ALT1, 1'b1, 1'b1);
        frm(1'b1, 1'b0, 1'b0, 1'b1, USR, 1'b1, 1'b1);
        frm(1'b1, 1'b0, 1'b1, 1'b0, `PTP_ADDR_ALT1, 1'b1, 1'b0);
        frm(1'b1, 1'b1, 1'b1, 1'b0, `PTP_ADDR_PRIMARY, 1'b0, 1'b0);
        // port 1 keeps its own reset group
        frm(1'b0, 1'b0, 1'b1, 1'b0, `PTP_ADDR_PRIMARY, 1'b1, 1'b1);
        frm(1'b0, 1'b0, 1'b1, 1'b0, USR, 1'b0, 1'b0);
        $display("test detection done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
